/* logic/cae_exec.sv */
`default_nettype none
`include "cae_regs.svh"

// Contract
// RULE_01 - add with or without carry, one cycle
// RULE_02 - word add immediate, two cycles, ZCNVS
// RULE_03 - word subtract immediate, one cycle, ZCNVS
// RULE_04 - subtract register or constant, one cycle
// RULE_05 - and/or forms one cycle, ZNV only
// RULE_06 - exclusive or one cycle, ZNV
// RULE_07 - set bits ORs mask, ZNV
// RULE_08 - clear bits ANDs with ff minus mask
// RULE_09 - zero minus test, value unchanged, ZNV
// RULE_10 - multiplies write R1:R0 in two cycles
// RULE_11 - fractional multiplies shift product left once
// RULE_12 - indirect jump loads pc from Z
// RULE_13 - calls take three cycles, no flags
// RULE_14 - compare skip equal skips on match
// RULE_15 - compares set flags, write nothing
// RULE_16 - skip on register bit clear/set
// RULE_17 - skip on io bit clear/set
// RULE_18 - branch on indexed flag adds offset plus one
// RULE_19 - branch: one cycle untaken, two taken
// RULE_20 - skip: one, two or three cycles
module cae_exec
   import cae_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic issue_valid,
   input wire cae_op_e issue_op,
   input wire logic [7:0] issue_rd,
   input wire logic [7:0] issue_rd_hi,
   input wire logic [7:0] issue_rr,
   input wire logic [7:0] issue_imm,
   input wire logic [7:0] issue_io,
   input wire logic [2:0] issue_bit,
   input wire logic [11:0] issue_offset,
   input wire logic issue_next_two_word,
   input wire logic [15:0] z_pointer,
   output logic ready,
   output logic done,
   output logic wr_lo_en,
   output logic [7:0] wr_lo_data,
   output logic wr_hi_en,
   output logic [7:0] wr_hi_data,
   output logic wr_fixed_pair,
   output logic [7:0] status_flags,
   output logic [15:0] pc,
   output logic push_en,
   output logic [15:0] push_addr
);

   cae_alu_if bus ();

   cae_alu u_alu (
      .bus (bus.alu)
   );

   cae_mul u_mul (
      .bus (bus.mul)
   );

   // ----------------------------------------
   // state
   // ----------------------------------------
   cae_state_e state;
   cae_state_e next_state;
   logic [1:0] remain;
   logic [1:0] next_remain;
   logic next_ready;
   logic next_done;
   logic next_wr_lo_en;
   logic [7:0] next_wr_lo_data;
   logic next_wr_hi_en;
   logic [7:0] next_wr_hi_data;
   logic next_wr_fixed_pair;
   logic [7:0] next_status_flags;
   logic [15:0] next_pc;
   logic next_push_en;
   logic [15:0] next_push_addr;

   // pending results held while a multi-cycle op runs
   logic pend_lo_en;
   logic [7:0] pend_lo;
   logic pend_hi_en;
   logic [7:0] pend_hi;
   logic pend_pair;
   logic [7:0] pend_flags;
   logic [15:0] pend_pc;
   logic pend_push;
   logic [15:0] pend_push_addr;
   logic next_pend_lo_en;
   logic [7:0] next_pend_lo;
   logic next_pend_hi_en;
   logic [7:0] next_pend_hi;
   logic next_pend_pair;
   logic [7:0] next_pend_flags;
   logic [15:0] next_pend_pc;
   logic next_pend_push;
   logic [15:0] next_pend_push_addr;

   // ----------------------------------------
   // decoded results of the issued op
   // ----------------------------------------
   logic [1:0] x_cycles;
   logic x_lo_en;
   logic [7:0] x_lo;
   logic x_hi_en;
   logic [7:0] x_hi;
   logic x_pair;
   logic [7:0] x_flags;
   logic [15:0] x_pc;
   logic x_push;
   logic [15:0] x_push_addr;

   logic [15:0] word_a;
   logic [16:0] word_sum;
   logic [16:0] word_dif;
   logic [15:0] branch_target;
   logic [15:0] skip_target;
   logic [1:0] skip_cycles;
   logic accept;

   function automatic logic [7:0] merge_flags(input logic [7:0] old, input logic [7:0] upd,
                                              input logic [7:0] mask);
      merge_flags = (old & ~mask) | (upd & mask);
   endfunction : merge_flags

   function automatic logic [7:0] pack_flags(input logic h, input logic s, input logic v,
                                             input logic n, input logic z, input logic c);
      logic [7:0] f;
      f = 8'h00;
      f[`CAE_FLAG_H] = h;
      f[`CAE_FLAG_S] = s;
      f[`CAE_FLAG_V] = v;
      f[`CAE_FLAG_N] = n;
      f[`CAE_FLAG_Z] = z;
      f[`CAE_FLAG_C] = c;
      pack_flags = f;
   endfunction : pack_flags

   assign accept = issue_valid & ready;

   // ----------------------------------------
   // operand selection for the shared units
   // ----------------------------------------
   always_comb
   begin
      bus.a = issue_rd;
      bus.b = issue_rr;
      bus.cin = 1'b0;
      bus.fn = fn_add;
      bus.mul_sa = 1'b0;
      bus.mul_sb = 1'b0;
      bus.mul_frac = 1'b0;
      unique case (issue_op)
         op_add_carry: bus.cin = status_flags[`CAE_FLAG_C];
         op_sub, op_compare: bus.fn = fn_sub;
         op_subtract_constant, op_compare_immediate:
         begin
            bus.fn = fn_sub;
            bus.b = issue_imm;
         end
         op_subtract_with_carry, op_compare_with_carry:
         begin
            bus.fn = fn_sub;
            bus.cin = status_flags[`CAE_FLAG_C];
         end
         op_subtract_const_with_carry:
         begin
            bus.fn = fn_sub;
            bus.b = issue_imm;
            bus.cin = status_flags[`CAE_FLAG_C];
         end
         op_and: bus.fn = fn_and;
         op_and_with_constant:
         begin
            bus.fn = fn_and;
            bus.b = issue_imm;
         end
         op_or: bus.fn = fn_or;
         op_or_with_constant, op_set_bits_op:
         begin
            bus.fn = fn_or;
            bus.b = issue_imm;
         end
         op_exclusive_or: bus.fn = fn_xor;
         op_clear_bits_op:
         begin
            bus.fn = fn_and;
            bus.b = 8'hff - issue_imm;
         end
         op_zero_minus_test:
         begin
            bus.fn = fn_and;
            bus.b = issue_rd;
         end
         op_signed_multiply, op_fractional_signed_multiply:
         begin
            bus.mul_sa = 1'b1;
            bus.mul_sb = 1'b1;
         end
         op_mixed_multiply, op_fractional_mixed_multiply: bus.mul_sa = 1'b1;
         default: bus.fn = fn_add;
      endcase
      if (issue_op == op_fractional_multiply || issue_op == op_fractional_signed_multiply
          || issue_op == op_fractional_mixed_multiply)
      begin
         bus.mul_frac = 1'b1;
      end
   end

   // ----------------------------------------
   // per-op result, flags, program counter and cycle count
   // ----------------------------------------
   always_comb
   begin
      word_a = {issue_rd_hi, issue_rd};
      word_sum = {1'b0, word_a} + {11'h000, issue_imm[5:0]};
      word_dif = {1'b0, word_a} - {11'h000, issue_imm[5:0]};
      branch_target = pc + {{4{issue_offset[11]}}, issue_offset} + 16'h0001;
      // a skipped two-word instruction costs one more word and one more cycle
      skip_target = issue_next_two_word ? pc + 16'h0003 : pc + 16'h0002;
      skip_cycles = issue_next_two_word ? `CAE_CYC_THREE : `CAE_CYC_TWO;
      x_cycles = `CAE_CYC_ONE;
      x_lo_en = 1'b0;
      x_lo = bus.res;
      x_hi_en = 1'b0;
      x_hi = 8'h00;
      x_pair = 1'b0;
      x_flags = status_flags;
      x_pc = pc + 16'h0001;
      x_push = 1'b0;
      x_push_addr = 16'h0000;
      unique case (issue_op)
         // RULE_01 add with carry
         // RULE_04 subtract forms
         op_add, op_add_carry, op_sub, op_subtract_constant, op_subtract_with_carry,
         op_subtract_const_with_carry:
         begin
            x_lo_en = 1'b1;
            x_flags = merge_flags(status_flags,
                                  pack_flags(bus.h, 1'b0, bus.v, bus.n, bus.z, bus.c),
                                  `CAE_MASK_ARITH);
         end
         // RULE_05 and/or forms
         // RULE_06 exclusive or
         // RULE_07 set bits
         // RULE_08 clear bits
         // RULE_09 test keeps value
         op_and, op_and_with_constant, op_or, op_or_with_constant, op_exclusive_or,
         op_set_bits_op, op_clear_bits_op, op_zero_minus_test:
         begin
            x_lo_en = (issue_op != op_zero_minus_test);
            x_flags = merge_flags(status_flags,
                                  pack_flags(1'b0, 1'b0, 1'b0, bus.n, bus.z, 1'b0),
                                  `CAE_MASK_LOGIC);
         end
         // RULE_02 word add
         op_word_add_immediate:
         begin
            x_cycles = `CAE_CYC_WORD_ADD;
            x_lo_en = 1'b1;
            x_hi_en = 1'b1;
            x_lo = word_sum[7:0];
            x_hi = word_sum[15:8];
            x_flags = merge_flags(status_flags,
                                  pack_flags(1'b0, word_sum[15] ^ (~word_a[15] & word_sum[15]),
                                             ~word_a[15] & word_sum[15], word_sum[15],
                                             word_sum[15:0] == 16'h0000, word_sum[16]),
                                  `CAE_MASK_WORD);
         end
         // RULE_03 word subtract
         op_word_subtract_immediate:
         begin
            x_cycles = `CAE_CYC_WORD_SUB;
            x_lo_en = 1'b1;
            x_hi_en = 1'b1;
            x_lo = word_dif[7:0];
            x_hi = word_dif[15:8];
            x_flags = merge_flags(status_flags,
                                  pack_flags(1'b0, word_dif[15] ^ (word_a[15] & ~word_dif[15]),
                                             word_a[15] & ~word_dif[15], word_dif[15],
                                             word_dif[15:0] == 16'h0000, word_dif[16]),
                                  `CAE_MASK_WORD);
         end
         // RULE_10 multiplies
         // RULE_11 fractional shift
         op_mul, op_signed_multiply, op_mixed_multiply, op_fractional_multiply,
         op_fractional_signed_multiply, op_fractional_mixed_multiply:
         begin
            x_cycles = `CAE_CYC_MUL;
            x_lo_en = 1'b1;
            x_hi_en = 1'b1;
            x_pair = 1'b1;
            x_lo = bus.prod[7:0];
            x_hi = bus.prod[15:8];
            x_flags = merge_flags(status_flags,
                                  pack_flags(1'b0, 1'b0, 1'b0, 1'b0, bus.mul_z, bus.mul_c),
                                  `CAE_MASK_MUL);
         end
         // RULE_12 jump via Z
         op_indirect_jump:
         begin
            x_cycles = `CAE_CYC_JUMP;
            x_pc = z_pointer;
         end
         // RULE_13 calls push return
         op_relative_call, op_indirect_call:
         begin
            x_cycles = `CAE_CYC_CALL;
            x_push = 1'b1;
            x_push_addr = pc + 16'h0001;
            x_pc = (issue_op == op_relative_call) ? branch_target : z_pointer;
         end
         // RULE_15 compare flags only
         op_compare, op_compare_with_carry, op_compare_immediate:
         begin
            x_flags = merge_flags(status_flags,
                                  pack_flags(bus.h, 1'b0, bus.v, bus.n, bus.z, bus.c),
                                  `CAE_MASK_ARITH);
         end
         // RULE_14 skip on equal
         // RULE_16 register bit
         // RULE_17 io bit
         // RULE_20 skip cycle count
         op_compare_skip_equal, op_skip_reg_bit_clear, op_skip_reg_bit_set,
         op_skip_io_bit_clear, op_skip_io_bit_set:
         begin
            if ((issue_op == op_compare_skip_equal && issue_rd == issue_rr)
                || (issue_op == op_skip_reg_bit_clear && !issue_rr[issue_bit])
                || (issue_op == op_skip_reg_bit_set && issue_rr[issue_bit])
                || (issue_op == op_skip_io_bit_clear && !issue_io[issue_bit])
                || (issue_op == op_skip_io_bit_set && issue_io[issue_bit]))
            begin
               x_pc = skip_target;
               x_cycles = skip_cycles;
            end
         end
         // RULE_18 flag branch
         // RULE_19 taken costs two
         op_branch_flag_set, op_branch_flag_clear:
         begin
            if (status_flags[issue_bit] == (issue_op == op_branch_flag_set))
            begin
               x_pc = branch_target;
               x_cycles = `CAE_CYC_TWO;
            end
         end
         default: x_cycles = `CAE_CYC_ONE;
      endcase
   end

   // ----------------------------------------
   // sequencing and commit
   // ----------------------------------------
   // results land on the edge that ends the op, so a following op
   // always sees the flags and pc of the one before it
   always_comb
   begin
      next_state = state;
      next_remain = remain;
      next_ready = ready;
      next_done = 1'b0;
      next_wr_lo_en = 1'b0;
      next_wr_lo_data = wr_lo_data;
      next_wr_hi_en = 1'b0;
      next_wr_hi_data = wr_hi_data;
      next_wr_fixed_pair = wr_fixed_pair;
      next_status_flags = status_flags;
      next_pc = pc;
      next_push_en = 1'b0;
      next_push_addr = push_addr;
      next_pend_lo_en = pend_lo_en;
      next_pend_lo = pend_lo;
      next_pend_hi_en = pend_hi_en;
      next_pend_hi = pend_hi;
      next_pend_pair = pend_pair;
      next_pend_flags = pend_flags;
      next_pend_pc = pend_pc;
      next_pend_push = pend_push;
      next_pend_push_addr = pend_push_addr;
      unique case (state)
         st_idle:
         begin
            if (accept && x_cycles == `CAE_CYC_ONE)
            begin
               next_done = 1'b1;
               next_wr_lo_en = x_lo_en;
               next_wr_lo_data = x_lo;
               next_wr_hi_en = x_hi_en;
               next_wr_hi_data = x_hi;
               next_wr_fixed_pair = x_pair;
               next_status_flags = x_flags;
               next_pc = x_pc;
               next_push_en = x_push;
               next_push_addr = x_push_addr;
            end
            else if (accept)
            begin
               next_state = st_run;
               next_ready = 1'b0;
               next_remain = x_cycles - `CAE_CYC_ONE;
               next_pend_lo_en = x_lo_en;
               next_pend_lo = x_lo;
               next_pend_hi_en = x_hi_en;
               next_pend_hi = x_hi;
               next_pend_pair = x_pair;
               next_pend_flags = x_flags;
               next_pend_pc = x_pc;
               next_pend_push = x_push;
               next_pend_push_addr = x_push_addr;
            end
         end
         st_run:
         begin
            next_remain = remain - `CAE_CYC_ONE;
            if (remain == `CAE_CYC_ONE)
            begin
               next_state = st_idle;
               next_ready = 1'b1;
               next_done = 1'b1;
               next_wr_lo_en = pend_lo_en;
               next_wr_lo_data = pend_lo;
               next_wr_hi_en = pend_hi_en;
               next_wr_hi_data = pend_hi;
               next_wr_fixed_pair = pend_pair;
               next_status_flags = pend_flags;
               next_pc = pend_pc;
               next_push_en = pend_push;
               next_push_addr = pend_push_addr;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state <= st_idle;
         remain <= 2'h0;
         ready <= 1'b1;
         done <= 1'b0;
         wr_lo_en <= 1'b0;
         wr_lo_data <= 8'h00;
         wr_hi_en <= 1'b0;
         wr_hi_data <= 8'h00;
         wr_fixed_pair <= 1'b0;
         status_flags <= `CAE_FLAGS_RESET;
         pc <= `CAE_PC_RESET;
         push_en <= 1'b0;
         push_addr <= 16'h0000;
         pend_lo_en <= 1'b0;
         pend_lo <= 8'h00;
         pend_hi_en <= 1'b0;
         pend_hi <= 8'h00;
         pend_pair <= 1'b0;
         pend_flags <= `CAE_FLAGS_RESET;
         pend_pc <= `CAE_PC_RESET;
         pend_push <= 1'b0;
         pend_push_addr <= 16'h0000;
      end
      else
      begin
         state <= next_state;
         remain <= next_remain;
         ready <= next_ready;
         done <= next_done;
         wr_lo_en <= next_wr_lo_en;
         wr_lo_data <= next_wr_lo_data;
         wr_hi_en <= next_wr_hi_en;
         wr_hi_data <= next_wr_hi_data;
         wr_fixed_pair <= next_wr_fixed_pair;
         status_flags <= next_status_flags;
         pc <= next_pc;
         push_en <= next_push_en;
         push_addr <= next_push_addr;
         pend_lo_en <= next_pend_lo_en;
         pend_lo <= next_pend_lo;
         pend_hi_en <= next_pend_hi_en;
         pend_hi <= next_pend_hi;
         pend_pair <= next_pend_pair;
         pend_flags <= next_pend_flags;
         pend_pc <= next_pend_pc;
         pend_push <= next_pend_push;
         pend_push_addr <= next_pend_push_addr;
      end
   end

endmodule : cae_exec

`default_nettype wire

/* logic/cae_regs.svh */
`ifndef CAE_REGS_SVH
`define CAE_REGS_SVH

// ----------------------------------------
// status flag bit positions
// ----------------------------------------
`define CAE_FLAG_C 0
`define CAE_FLAG_Z 1
`define CAE_FLAG_N 2
`define CAE_FLAG_V 3
`define CAE_FLAG_S 4
`define CAE_FLAG_H 5

// ----------------------------------------
// flag update masks per instruction class
// ----------------------------------------
`define CAE_MASK_ARITH 8'h2f
`define CAE_MASK_WORD 8'h1f
`define CAE_MASK_LOGIC 8'h0e
`define CAE_MASK_MUL 8'h03

// ----------------------------------------
// reset values
// ----------------------------------------
`define CAE_PC_RESET 16'h0000
`define CAE_FLAGS_RESET 8'h00

// ----------------------------------------
// cycle counts
// ----------------------------------------
`define CAE_CYC_ONE 2'h1
`define CAE_CYC_TWO 2'h2
`define CAE_CYC_THREE 2'h3
`define CAE_CYC_WORD_ADD 2'h2
`define CAE_CYC_WORD_SUB 2'h1
`define CAE_CYC_MUL 2'h2
`define CAE_CYC_JUMP 2'h2
`define CAE_CYC_CALL 2'h3

`endif

/* logic/cae_pkg.sv */
`default_nettype none

package cae_pkg;

   // ----------------------------------------
   // decoded operations
   // ----------------------------------------
   typedef enum logic [5:0] {
      op_add, op_add_carry, op_word_add_immediate, op_sub, op_subtract_constant,
      op_subtract_with_carry, op_subtract_const_with_carry, op_word_subtract_immediate,
      op_and, op_and_with_constant, op_or, op_or_with_constant, op_exclusive_or,
      op_set_bits_op, op_clear_bits_op, op_zero_minus_test,
      op_mul, op_signed_multiply, op_mixed_multiply, op_fractional_multiply,
      op_fractional_signed_multiply, op_fractional_mixed_multiply,
      op_indirect_jump, op_relative_call, op_indirect_call,
      op_compare_skip_equal, op_compare, op_compare_with_carry, op_compare_immediate,
      op_skip_reg_bit_clear, op_skip_reg_bit_set, op_skip_io_bit_clear,
      op_skip_io_bit_set, op_branch_flag_set, op_branch_flag_clear, op_nop
   } cae_op_e;

   typedef enum logic [2:0] {
      fn_add, fn_sub, fn_and, fn_or, fn_xor
   } cae_fn_e;

   typedef enum logic {
      st_idle = 1'b0,
      st_run = 1'b1
   } cae_state_e;

endpackage : cae_pkg

`default_nettype wire

/* logic/cae_alu_if.sv */
`default_nettype none

interface cae_alu_if;
   import cae_pkg::*;
   logic [7:0] a;
   logic [7:0] b;
   logic cin;
   cae_fn_e fn;
   logic [7:0] res;
   logic h;
   logic v;
   logic n;
   logic z;
   logic c;
   logic mul_sa;
   logic mul_sb;
   logic mul_frac;
   logic [15:0] prod;
   logic mul_c;
   logic mul_z;

   modport core (output a, b, cin, fn, mul_sa, mul_sb, mul_frac,
                 input res, h, v, n, z, c, prod, mul_c, mul_z);
   modport alu (input a, b, cin, fn, output res, h, v, n, z, c);
   modport mul (input a, b, mul_sa, mul_sb, mul_frac, output prod, mul_c, mul_z);
endinterface : cae_alu_if

`default_nettype wire

/* logic/cae_alu.sv */
`default_nettype none

module cae_alu
   import cae_pkg::*;
(
   cae_alu_if.alu bus
);

   logic [8:0] sum;
   logic [4:0] nib;
   logic a7;
   logic b7;
   logic r7;

   // ----------------------------------------
   // byte datapath and flags
   // ----------------------------------------
   always_comb
   begin
      sum = 9'h000;
      nib = 5'h00;
      bus.h = 1'b0;
      bus.v = 1'b0;
      bus.c = 1'b0;
      a7 = bus.a[7];
      b7 = bus.b[7];
      unique case (bus.fn)
         fn_add:
         begin
            sum = {1'b0, bus.a} + {1'b0, bus.b} + {8'h00, bus.cin};
            nib = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]} + {4'h0, bus.cin};
         end
         fn_sub:
         begin
            // borrow shows as the ninth bit of the difference
            sum = {1'b0, bus.a} - {1'b0, bus.b} - {8'h00, bus.cin};
            nib = {1'b0, bus.a[3:0]} - {1'b0, bus.b[3:0]} - {4'h0, bus.cin};
         end
         fn_and: sum = {1'b0, bus.a & bus.b};
         fn_or: sum = {1'b0, bus.a | bus.b};
         fn_xor: sum = {1'b0, bus.a ^ bus.b};
         default: sum = 9'h000;
      endcase
      r7 = sum[7];
      if (bus.fn == fn_add)
      begin
         bus.h = nib[4];
         bus.c = sum[8];
         bus.v = (a7 & b7 & ~r7) | (~a7 & ~b7 & r7);
      end
      else if (bus.fn == fn_sub)
      begin
         bus.h = nib[4];
         bus.c = sum[8];
         bus.v = (a7 & ~b7 & ~r7) | (~a7 & b7 & r7);
      end
      bus.res = sum[7:0];
      bus.n = r7;
      bus.z = (sum[7:0] == 8'h00);
   end

endmodule : cae_alu

`default_nettype wire

/* logic/cae_mul.sv */
`default_nettype none

module cae_mul
   import cae_pkg::*;
(
   cae_alu_if.mul bus
);

   logic signed [17:0] full;
   logic [15:0] raw;

   // ----------------------------------------
   // nine-bit operands cover all three signedness mixes
   // ----------------------------------------
   always_comb
   begin
      full = $signed({bus.mul_sa & bus.a[7], bus.a}) * $signed({bus.mul_sb & bus.b[7], bus.b});
      raw = full[15:0];
      // carry is taken from the product before the fractional shift
      bus.mul_c = raw[15];
      bus.prod = bus.mul_frac ? {raw[14:0], 1'b0} : raw;
      bus.mul_z = (bus.prod == 16'h0000);
   end

endmodule : cae_mul

`default_nettype wire

/* testbench/cae_exec_props.sv */
`default_nettype none
module cae_exec_props
   import cae_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic issue_valid,
   input wire cae_op_e issue_op,
   input wire logic [7:0] issue_rd,
   input wire logic [7:0] issue_rr,
   input wire logic [2:0] issue_bit,
   input wire logic issue_next_two_word,
   input wire logic [15:0] z_pointer,
   input wire logic ready,
   input wire logic done,
   input wire logic wr_lo_en,
   input wire logic [7:0] wr_lo_data,
   input wire logic wr_hi_en,
   input wire logic wr_fixed_pair,
   input wire logic [7:0] status_flags,
   input wire logic [15:0] pc,
   input wire logic push_en,
   input wire logic [15:0] push_addr
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   // flags are stable at the taking edge, so they may qualify a request
   wire logic tk = issue_valid & ready;
   a_add_one: assert property (tk && issue_op == op_add
      |=> done && ready && wr_lo_en) else $error("add timing");
   a_and_flags: assert property (tk && issue_op == op_and
      |=> wr_lo_data == ($past(issue_rd) & $past(issue_rr)) && !status_flags[3])
      else $error("and result");
   a_mul_two: assert property (tk && issue_op == op_mul
      |=> !ready ##1 done && wr_fixed_pair && wr_hi_en) else $error("mul timing");
   a_jump_z: assert property (tk && issue_op == op_indirect_jump
      |=> !ready ##1 done && pc == $past(z_pointer, 2)) else $error("jump target");
   a_call_three: assert property (tk && issue_op == op_relative_call
      |=> !ready [*2] ##1 push_en && push_addr == $past(pc, 3) + 16'h0001)
      else $error("call timing");
   a_cmp_nowrite: assert property (tk && issue_op == op_compare
      |=> done && !wr_lo_en && !wr_hi_en) else $error("compare wrote");
   a_branch_miss: assert property (tk && issue_op == op_branch_flag_set
      && !status_flags[issue_bit] |=> done && pc == $past(pc) + 16'h0001)
      else $error("branch not taken");
   a_skip_far: assert property (tk && issue_op == op_skip_reg_bit_set
      && issue_rr[issue_bit] && issue_next_two_word |=> !ready [*2] ##1 done
      && pc == $past(pc, 3) + 16'h0003) else $error("skip two words");
endmodule : cae_exec_props
`default_nettype wire

/* testbench/cae_exec_bench.sv */
`default_nettype none
module cae_exec_bench import cae_pkg::*; ();
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 0, reset_n = 0, issue_valid = 0, issue_next_two_word = 0, push_en;
   logic ready, done, wr_lo_en, wr_hi_en, wr_fixed_pair;
   cae_op_e issue_op = op_nop;
   logic [7:0] issue_rd = '0, issue_rr = '0, issue_io = '0, wr_lo_data, wr_hi_data;
   logic [7:0] status_flags, fl_m = '0;
   logic [2:0] issue_bit = '0;
   logic [11:0] issue_offset = '0;
   logic [15:0] z_pointer = '0, pc, push_addr, pc_m = '0;
   int seed = 82769, n_mismatch = 0, checked = 0;
   cae_op_e ops[14] = '{op_add, op_sub, op_compare, op_and, op_zero_minus_test, op_mul,
      op_indirect_jump, op_relative_call, op_branch_flag_set, op_branch_flag_clear,
      op_skip_reg_bit_set, op_skip_reg_bit_clear, op_skip_io_bit_set, op_skip_io_bit_clear};
   always #12.5 clk = ~clk;
   cae_exec i_dut (.clk, .reset_n, .issue_valid, .issue_op, .issue_rd, .issue_rd_hi(8'h00),
      .issue_rr, .issue_imm(8'h00), .issue_io, .issue_bit, .issue_offset,
      .issue_next_two_word, .z_pointer, .ready, .done, .wr_lo_en, .wr_lo_data, .wr_hi_en,
      .wr_hi_data, .wr_fixed_pair, .status_flags, .pc, .push_en, .push_addr);
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic finish_test;
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : finish_test
   task automatic run(input cae_op_e op);
      logic [7:0] a, b;
      logic [8:0] r;
      logic [15:0] p, e;
      logic [11:0] k;
      logic [2:0] s;
      logic t;
      int n, w, zn, c;
      {a, b, k, s, t} = $random(seed);
      @(posedge clk);
      {issue_valid, issue_op, issue_rd, issue_rr, issue_io} <= {1'b1, op, a, b, b};
      {issue_bit, issue_offset, issue_next_two_word, z_pointer} <= {s, k, t, a, b};
      e = pc_m + 16'h0001;
      n = 1;
      w = 0;
      zn = 1;
      p = '0;
      case (op)
         op_add:
         begin
            r = a + b;
            {p, w, fl_m[0]} = {8'h00, r[7:0], 32'd1, r[8]};
            fl_m[5] = (a[3:0] + b[3:0]) > 5'h0f;
            fl_m[3] = a[7] == b[7] && r[7] != a[7];
         end
         op_sub, op_compare:
         begin
            r = a - b;
            {p, w, fl_m[0]} = {8'h00, r[7:0], 32'(op == op_sub), r[8]};
            fl_m[5] = a[3:0] < b[3:0];
            fl_m[3] = a[7] != b[7] && r[7] != a[7];
         end
         op_and, op_zero_minus_test:
         begin
            p = (op == op_and) ? a & b : a;
            w = op == op_and;
            fl_m[3] = 1'b0;
         end
         op_mul:
         begin
            p = a * b;
            {w, n, zn} = {32'd2, 32'd2, 32'd0};
            fl_m[1:0] = {p == 16'h0000, p[15]};
         end
         op_indirect_jump: {e, n, zn} = {a, b, 32'd2, 32'd0};
         op_relative_call: {e, n, zn} = {pc_m + {{4{k[11]}}, k} + 16'h0001, 32'd3, 32'd0};
         op_branch_flag_set, op_branch_flag_clear:
         begin
            zn = 0;
            if (fl_m[s] == (op == op_branch_flag_set))
               {e, n} = {pc_m + {{4{k[11]}}, k} + 16'h0001, 32'd2};
         end
         default:
         begin
            zn = 0;
            // a skipped two-word instruction costs one cycle more
            if (b[s] == (op inside {op_skip_reg_bit_set, op_skip_io_bit_set}))
               {e, n} = {pc_m + (t ? 16'h0003 : 16'h0002), (t ? 32'd3 : 32'd2)};
         end
      endcase
      if (zn != 0)
         fl_m[2:1] = {p[7], p[7:0] == 8'h00};
      @(posedge clk);
      issue_valid <= 1'b0;
      #1;
      c = 1;
      while (done !== 1'b1 && c < 9)
      begin
         @(posedge clk);
         #1;
         c++;
      end
      chk(16'(c), 16'(n));
      chk(pc, e);
      chk(status_flags, fl_m);
      chk({wr_lo_en, wr_hi_en}, {w != 0, w == 2});
      if (w != 0)
         chk(wr_lo_data, p[7:0]);
      if (w == 2)
         chk({wr_hi_data, wr_fixed_pair}, {p[15:8], 1'b1});
      chk(push_en, op == op_relative_call);
      if (op == op_relative_call)
         chk(push_addr, pc_m + 16'h0001);
      pc_m = e;
   endtask : run
   initial
   begin
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      repeat (300) run(ops[$unsigned($random(seed)) % 14]);
      $display("random instruction mix done");
      finish_test;
   end
   initial
   begin
      #(25 * 3000);
      n_mismatch++;
      finish_test;
   end
endmodule : cae_exec_bench
bind cae_exec cae_exec_props i_props (.clk, .reset_n, .issue_valid, .issue_op, .issue_rd,
   .issue_rr, .issue_bit, .issue_next_two_word, .z_pointer, .ready, .done, .wr_lo_en,
   .wr_lo_data, .wr_hi_en, .wr_fixed_pair, .status_flags, .pc, .push_en, .push_addr);
`default_nettype wire
